// File: design/pct_capture.sv
/*
 pct_capture: capture trigger, block capture memory and readout engine
 of a bit-error detector, with an AXI4-Lite register slave.
 Assumes rx stream and bus share core_clk_in; aux pin is asynchronous.
*/
`timescale 1ns/1ps
module pct_capture (
  input  wire logic             core_clk_in,
  input  wire logic             srst_in,
  input  wire pct_pkg::pct_rx_s rx_in,
  input  wire logic             aux_trig_n_in,
  input  wire logic             s_axi_awvalid,
  input  wire logic [7:0]       s_axi_awaddr,
  output logic                  s_axi_awready,
  input  wire logic             s_axi_wvalid,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  output logic                  s_axi_wready,
  output logic                  s_axi_bvalid,
  output logic [1:0]            s_axi_bresp,
  input  wire logic             s_axi_bready,
  input  wire logic             s_axi_arvalid,
  input  wire logic [7:0]       s_axi_araddr,
  output logic                  s_axi_arready,
  output logic                  s_axi_rvalid,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  input  wire logic             s_axi_rready,
  output logic                  irq_out
);
  import pct_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) o[i*8 +: 8] = d[i*8 +: 8];
    end
    return o;
  endfunction

  function automatic logic known(input logic [7:0] a);
    return a <= IRQ_CLR_OFS && a[1:0] == 2'b00;
  endfunction

  // ==========================================================
  // bus slave
  logic              awr_q, wr_q, bv_q, arr_q, rv_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [31:0]       rdata_q, wdat_q;
  logic [3:0]        wstrb_q;
  logic [7:0]        waddr_q;
  logic              aw_have_q, w_have_q;
  logic [31:0]       cfg_q, mlo_q, mhi_q, klo_q, khi_q, rcnt_q;
  logic [BLK_AW-1:0] rstart_q;
  logic [IRQ_W-1:0]  ists_q, ien_q, iset;
  logic              irq_q;
  pct_cfg_s          cfg;
  wire               wr_fire = aw_have_q && w_have_q && !bv_q;
  wire               ctrl_wr = wr_fire && waddr_q == CTRL_OFS;
  wire               cap_go  = ctrl_wr && wstrb_q[0] && wdat_q[CTRL_CAP_BIT];
  wire               man_cmd = ctrl_wr && wstrb_q[0] && wdat_q[CTRL_MAN_BIT];
  wire               rd_go   = ctrl_wr && wstrb_q[0] && wdat_q[CTRL_RD_BIT];
  wire               rd_abt  = ctrl_wr && wstrb_q[0]
                               && wdat_q[CTRL_ABORT_BIT];
  wire               ar_fire = s_axi_arvalid && arr_q;
  assign cfg = pct_cfg_s'(cfg_q);

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      awr_q <= 1'b1; wr_q <= 1'b1; bv_q <= 1'b0; bresp_q <= 2'b00;
      aw_have_q <= 1'b0; w_have_q <= 1'b0;
      waddr_q <= 8'h00; wdat_q <= 32'h0; wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && awr_q) begin
        awr_q <= 1'b0; aw_have_q <= 1'b1; waddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wr_q) begin
        wr_q <= 1'b0; w_have_q <= 1'b1;
        wdat_q <= s_axi_wdata; wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bv_q <= 1'b1; aw_have_q <= 1'b0; w_have_q <= 1'b0;
        bresp_q <= known(waddr_q) ? 2'b00 : 2'b11;
      end
      if (bv_q && s_axi_bready) begin
        bv_q <= 1'b0; awr_q <= 1'b1; wr_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      cfg_q <= CFG_RST; mlo_q <= PAT_RST[31:0]; mhi_q <= PAT_RST[63:32];
      klo_q <= PAT_RST[31:0]; khi_q <= PAT_RST[63:32];
      rstart_q <= 7'h00; rcnt_q <= 32'h0; ien_q <= 3'h0;
    end else if (wr_fire) begin
      case (waddr_q)
        CFG_OFS:      cfg_q <= merge(cfg_q, wdat_q, wstrb_q) & CFG_WMASK;
        MATCH_LO_OFS: mlo_q <= merge(mlo_q, wdat_q, wstrb_q);
        MATCH_HI_OFS: mhi_q <= merge(mhi_q, wdat_q, wstrb_q);
        MASK_LO_OFS:  klo_q <= merge(klo_q, wdat_q, wstrb_q);
        MASK_HI_OFS:  khi_q <= merge(khi_q, wdat_q, wstrb_q);
        RD_START_OFS: if (wstrb_q[0]) rstart_q <= wdat_q[6:0];
        RD_COUNT_OFS: rcnt_q <= merge(rcnt_q, wdat_q, wstrb_q) & 32'hff;
        IRQ_EN_OFS:   if (wstrb_q[0]) ien_q <= wdat_q[IRQ_W-1:0];
        default:      ;
      endcase
    end
  end

  // set wins over a clear in the same cycle
  wire [IRQ_W-1:0] iclr = (wr_fire && waddr_q == IRQ_CLR_OFS
                           && wstrb_q[0]) ? wdat_q[IRQ_W-1:0] : 3'h0;
  wire [IRQ_W-1:0] ists_d = (ists_q & ~iclr) | iset;
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ists_q <= 3'h0; irq_q <= 1'b0;
    end else begin
      ists_q <= ists_d;
      irq_q <= |(ists_d & ien_q);
    end
  end

  // ==========================================================
  // aux pin synchroniser and edge detect
  logic aux1_q, aux2_q, aux3_q;
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      aux1_q <= 1'b1; aux2_q <= 1'b1; aux3_q <= 1'b1;
    end else begin
      aux1_q <= aux_trig_n_in; aux2_q <= aux1_q; aux3_q <= aux2_q;
    end
  end
  wire aux_fall = aux3_q && !aux2_q;

  // ==========================================================
  // geometry: block length is the memory divided by block count
  wire [OFS_W:0]     blen   = 24'h80_0000 >> cfg.nblk_log2;
  wire [OFS_W-1:0]   bmask  = OFS_W'(blen - 24'h1);
  wire [MEM_AW-1:0]  ymask  = bmask[OFS_W-1:3];
  wire [7:0]         nblk   = 8'h01 << cfg.nblk_log2;

  // ==========================================================
  // match detector
  logic [63:0] sr_q;
  logic [1:0]  nib_q;
  wire  [63:0] sr_nx  = {sr_q[62:0], rx_in.rx_bit};
  wire  [6:0]  nbits  = {cfg.len_code, 2'b00} + 7'd4;
  wire  [63:0] lmask  = ~({64{1'b1}} << nbits);
  wire  [63:0] cmpm   = lmask & ~{khi_q, klo_q};
  wire         m_hit  = ((sr_nx ^ {mhi_q, mlo_q}) & cmpm) == 64'h0
                        && (!cfg.two_channel_combined_mode
                            || nib_q == 2'b11);
  wire         e_hit  = rx_in.rx_bit ^ rx_in.ref_bit;
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      sr_q <= 64'h0; nib_q <= 2'b00;
    end else if (rx_in.valid) begin
      sr_q <= sr_nx; nib_q <= nib_q + 2'b01;
    end
  end

  // ==========================================================
  // capture engine
  pct_cap_e          cst_q;
  logic [OFS_W-1:0]  ptr_q, tpos_q, post_q;
  logic [OFS_W:0]    fill_q;
  logic [BLK_AW:0]   bcnt_q;
  logic [7:0]        bv_val_q, bv_err_q;
  logic              man_q, ext_q;
  logic [15:0]       mem [0:(1<<MEM_AW)-1];
  logic [OFS_W-1:0]  tofs_mem [0:(1<<BLK_AW)-1];
  logic [MEM_AW-1:0] strt_mem [0:(1<<BLK_AW)-1];
  wire  [7:0]        onehot = 8'h01 << ptr_q[2:0];
  wire  [7:0]        val_nx = rx_in.rx_bit ? (bv_val_q | onehot)
                                           : (bv_val_q & ~onehot);
  wire  [7:0]        err_nx = e_hit ? (bv_err_q | onehot)
                                    : (bv_err_q & ~onehot);
  wire  [MEM_AW-1:0] wbase  = MEM_AW'({13'h0, bcnt_q[6:0]}
                                      << (MEM_AW - 3'(cfg.nblk_log2)));
  wire               ins_v  = rx_in.valid && cst_q != C_IDLE;
  wire               fire   = cst_q == C_ARM && rx_in.valid && (
                     cfg.src == SRC_ERR    ? e_hit :
                     cfg.src == SRC_MATCH  ? m_hit :
                     cfg.src == SRC_MANUAL ? man_q : ext_q);
  wire  [OFS_W:0]    fill_nx = (fill_q == blen) ? fill_q
                                                : fill_q + 24'h1;
  wire               freeze = cst_q == C_POST && rx_in.valid
                              && post_q == 23'h0 && ptr_q[2:0] == 3'h7;
  wire  [OFS_W-1:0]  ptr_nx = (ptr_q + 23'h1) & bmask;
  // once full, the oldest bit is the one after the last written
  wire  [OFS_W-1:0]  sbit   = (fill_nx == blen) ? ptr_nx : 23'h0;
  wire  [OFS_W-1:0]  post_need = cfg.place == PL_TOP ? OFS_W'(blen - 24'h8)
                               : cfg.place == PL_MIDDLE ? blen[OFS_W:1]
                               : 23'h0;
  wire               last_blk = bcnt_q + 8'h01 == {1'b0, nblk};

  always_ff @(posedge core_clk_in) begin
    if (ins_v) begin
      if (ptr_q[2:0] == 3'h7)
        mem[wbase | ptr_q[OFS_W-1:3]] <= {err_nx, val_nx};
    end
    if (freeze) begin
      tofs_mem[bcnt_q[6:0]] <= (tpos_q - sbit) & bmask;
      strt_mem[bcnt_q[6:0]] <= sbit[OFS_W-1:3];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      cst_q <= C_IDLE; ptr_q <= 23'h0; tpos_q <= 23'h0; post_q <= 23'h0;
      fill_q <= 24'h0; bcnt_q <= 8'h00; bv_val_q <= 8'h00;
      bv_err_q <= 8'h00; man_q <= 1'b0; ext_q <= 1'b0;
    end else begin
      // trigger events wait for the next received bit
      if (cst_q != C_ARM || fire) begin
        man_q <= 1'b0; ext_q <= 1'b0;
      end else begin
        if (man_cmd) man_q <= 1'b1;
        if (aux_fall) ext_q <= 1'b1;
      end
      if (ins_v) begin
        bv_val_q <= val_nx; bv_err_q <= err_nx;
        ptr_q <= ptr_nx; fill_q <= fill_nx;
      end
      case (cst_q)
        C_IDLE: if (cap_go) begin
          cst_q <= C_ARM; bcnt_q <= 8'h00; ptr_q <= 23'h0;
          fill_q <= 24'h0;
        end
        C_ARM: if (fire) begin
          cst_q <= C_POST; tpos_q <= ptr_q; post_q <= post_need;
        end
        C_POST: if (rx_in.valid) begin
          if (freeze) begin
            bcnt_q <= bcnt_q + 8'h01;
            cst_q <= last_blk ? C_IDLE : C_ARM;
            ptr_q <= 23'h0; fill_q <= 24'h0;
          end else if (post_q != 23'h0) begin
            post_q <= post_q - 23'h1;
          end
        end
        default: cst_q <= C_IDLE;
      endcase
    end
  end

  // ==========================================================
  // readout engine
  pct_rd_e           rst_q;
  logic [BLK_AW-1:0] rblk_q, rlast_q;
  logic [MEM_AW-1:0] rk_q;
  logic [15:0]       rdat_q, rhold_q;
  // one spare bit: start plus count may pass 255
  wire  [BLK_AW+1:0] cnt_end = {2'b00, rstart_q} + {1'b0, rcnt_q[7:0]};
  wire  [BLK_AW:0]   lim     = (cnt_end > {1'b0, bcnt_q}) ? bcnt_q
                               : cnt_end[BLK_AW:0];
  wire  [BLK_AW:0]   first   = cfg.read_all ? 8'h00 : {1'b0, rstart_q};
  wire  [BLK_AW:0]   stop    = cfg.read_all ? bcnt_q : lim;
  wire  [MEM_AW-1:0] raddr   = MEM_AW'({13'h0, rblk_q}
                               << (MEM_AW - 3'(cfg.nblk_log2)))
                               | ((strt_mem[rblk_q] + rk_q) & ymask);
  wire               pop     = ar_fire && s_axi_araddr == RD_DATA_OFS
                               && rst_q == R_HOLD;
  wire               rbusy   = rst_q != R_IDLE;
  always_ff @(posedge core_clk_in) rdat_q <= mem[raddr];

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      rst_q <= R_IDLE; rblk_q <= 7'h00; rlast_q <= 7'h00;
      rk_q <= 20'h0; rhold_q <= 16'h0;
    end else if (rd_abt) begin
      rst_q <= R_IDLE;
    end else begin
      case (rst_q)
        R_IDLE: if (rd_go && first < stop) begin
          rst_q <= R_ADDR; rblk_q <= first[6:0];
          rlast_q <= 7'(stop - 8'h01); rk_q <= 20'h0;
        end
        R_ADDR: rst_q <= R_DATA;
        R_DATA: begin
          rst_q <= R_HOLD; rhold_q <= rdat_q;
        end
        R_HOLD: if (pop) begin
          if (rk_q == ymask) begin
            rk_q <= 20'h0; rblk_q <= rblk_q + 7'h01;
            rst_q <= (rblk_q == rlast_q) ? R_IDLE : R_ADDR;
          end else begin
            rk_q <= rk_q + 20'h1; rst_q <= R_ADDR;
          end
        end
        default: rst_q <= R_IDLE;
      endcase
    end
  end

  // byte entry: values, insertion, omission, group flags
  wire [7:0]  g_ins = rhold_q[15:8] & rhold_q[7:0];
  wire [7:0]  g_om  = rhold_q[15:8] & ~rhold_q[7:0];
  wire [31:0] rd_word = {rst_q == R_HOLD, 5'h0, |g_om, |g_ins,
                         g_om, g_ins, rhold_q[7:0]};
  wire        rd_done = (rst_q == R_HOLD && pop && rk_q == ymask
                         && rblk_q == rlast_q)
                        || (rd_go && rst_q == R_IDLE && first >= stop);
  assign iset = {rd_done || (rd_abt && rbusy),
                 freeze && last_blk, freeze};

  // ==========================================================
  // read mux
  wire [31:0] rd_mux =
    s_axi_araddr == CFG_OFS      ? cfg_q :
    s_axi_araddr == MATCH_LO_OFS ? mlo_q :
    s_axi_araddr == MATCH_HI_OFS ? mhi_q :
    s_axi_araddr == MASK_LO_OFS  ? klo_q :
    s_axi_araddr == MASK_HI_OFS  ? khi_q :
    s_axi_araddr == STATUS_OFS   ? {16'h0, bcnt_q, 6'h0, rbusy,
                                    cst_q != C_IDLE} :
    s_axi_araddr == TRIG_OFS_OFS ? {9'h0, tofs_mem[rstart_q]} :
    s_axi_araddr == RD_START_OFS ? {25'h0, rstart_q} :
    s_axi_araddr == RD_COUNT_OFS ? rcnt_q :
    s_axi_araddr == RD_DATA_OFS  ? rd_word :
    s_axi_araddr == IRQ_STS_OFS  ? {29'h0, ists_q} :
    s_axi_araddr == IRQ_EN_OFS   ? {29'h0, ien_q} : 32'h0;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      arr_q <= 1'b1; rv_q <= 1'b0; rdata_q <= 32'h0; rresp_q <= 2'b00;
    end else if (ar_fire) begin
      arr_q <= 1'b0; rv_q <= 1'b1; rdata_q <= rd_mux;
      rresp_q <= known(s_axi_araddr) ? 2'b00 : 2'b11;
    end else if (rv_q && s_axi_rready) begin
      arr_q <= 1'b1; rv_q <= 1'b0;
    end
  end

  assign s_axi_awready = awr_q;
  assign s_axi_wready  = wr_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arr_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign irq_out       = irq_q;
endmodule

// File: design/pct_pkg.sv
/*
 pct_pkg: register map, field layout, reset values and the types shared
 by the pattern capture trigger. Assumes a 32-bit AXI4-Lite register bus.
*/
package pct_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam int          AW             = 8;
  localparam logic [7:0]  CTRL_OFS       = 8'h00;
  localparam logic [7:0]  CFG_OFS        = 8'h04;
  localparam logic [7:0]  MATCH_LO_OFS   = 8'h08;
  localparam logic [7:0]  MATCH_HI_OFS   = 8'h0c;
  localparam logic [7:0]  MASK_LO_OFS    = 8'h10;
  localparam logic [7:0]  MASK_HI_OFS    = 8'h14;
  localparam logic [7:0]  STATUS_OFS     = 8'h18;
  localparam logic [7:0]  TRIG_OFS_OFS   = 8'h1c;
  localparam logic [7:0]  RD_START_OFS   = 8'h20;
  localparam logic [7:0]  RD_COUNT_OFS   = 8'h24;
  localparam logic [7:0]  RD_DATA_OFS    = 8'h28;
  localparam logic [7:0]  IRQ_STS_OFS    = 8'h2c;
  localparam logic [7:0]  IRQ_EN_OFS     = 8'h30;
  localparam logic [7:0]  IRQ_CLR_OFS    = 8'h34;
  // ==========================================================
  // control bits (write one for a pulse), read-data valid bit and interrupt bits
  localparam int          CTRL_CAP_BIT   = 0;
  localparam int          CTRL_MAN_BIT   = 1;
  localparam int          CTRL_RD_BIT    = 4;
  localparam int          CTRL_ABORT_BIT = 5;
  localparam int          RD_VALID_BIT   = 31;
  localparam int          IRQ_BLOCK_BIT  = 0;
  localparam int          IRQ_DONE_BIT   = 1;
  localparam int          IRQ_READ_BIT   = 2;
  localparam int          IRQ_W          = 3;
  // ==========================================================
  // reset values and sizes
  localparam logic [31:0] CFG_RST        = 32'h0000_0f00;
  localparam logic [31:0] CFG_WMASK      = 32'h0000_1fff;
  localparam logic [63:0] PAT_RST        = 64'h0;
  localparam int          MEM_BITS_LOG2  = 23;
  localparam int          MEM_AW         = 20;
  localparam int          BLK_AW         = 7;
  localparam int          OFS_W          = 23;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    SRC_ERR = 2'b00, SRC_MATCH = 2'b01, SRC_MANUAL = 2'b10, SRC_EXT = 2'b11
  } pct_src_e;
  typedef enum logic [1:0] {
    PL_TOP = 2'b00, PL_MIDDLE = 2'b01, PL_BOTTOM = 2'b10, PL_RSVD = 2'b11
  } pct_place_e;
  typedef enum logic [1:0] {
    C_IDLE = 2'b00, C_ARM = 2'b01, C_POST = 2'b10
  } pct_cap_e;
  typedef enum logic [1:0] {
    R_IDLE = 2'b00, R_ADDR = 2'b01, R_DATA = 2'b10, R_HOLD = 2'b11
  } pct_rd_e;
  typedef struct packed {
    logic [18:0] unused;
    logic        read_all;
    logic [3:0]  len_code;
    logic        two_channel_combined_mode;
    pct_place_e  place;
    pct_src_e    src;
    logic [2:0]  nblk_log2;
  } pct_cfg_s;
  typedef struct packed {
    logic valid;
    logic rx_bit;
    logic ref_bit;
  } pct_rx_s;
endpackage

// File: tb/pattern_capture_trigger_test.sv
/*
 bench top for pct_capture: AXI4-Lite master tasks, stream model.
 Assumes one 40 MHz clock and a synchronous reset.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  fails++; $display("CHECK FAILED t=%0t got=%h exp=%h", \
  $time, g, e); end end
module pattern_capture_trigger_test;
  import pct_pkg::*;
  logic        core_clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        aux_n = 1'b1;
  logic        awv = 1'b0, wv = 1'b0, bre = 1'b0;
  logic        arv = 1'b0, rre = 1'b0, st = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd, rdat;
  logic [15:0] rxw = 16'h0, rfw = 16'h0;
  logic [1:0]  rsp, brsp, rrsp;
  logic        awr, wrd, bv, arr, rv, irq;
  pct_rx_s     rx;
  int          fails = 0;
  int          checks_done = 0;
  always #12.5 core_clk_in = ~core_clk_in;
  pct_capture u_pct_capture (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .rx_in(rx),
    .aux_trig_n_in(aux_n), .s_axi_awvalid(awv), .s_axi_awaddr(awa),
    .s_axi_awready(awr), .s_axi_wvalid(wv), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hf), .s_axi_wready(wrd), .s_axi_bvalid(bv),
    .s_axi_bresp(brsp), .s_axi_bready(bre), .s_axi_arvalid(arv),
    .s_axi_araddr(ara), .s_axi_arready(arr), .s_axi_rvalid(rv),
    .s_axi_rdata(rdat), .s_axi_rresp(rrsp), .s_axi_rready(rre),
    .irq_out(irq));
  pct_stream_src u_pct_stream_src (.core_clk_in(core_clk_in),
    .srst_in(srst_in), .start_in(st), .rx_word_in(rxw),
    .ref_word_in(rfw), .rx_out(rx));
  // ==========================================================
  // bus and stream tasks
  function automatic logic [31:0] cfg(input logic [2:0] n,
    input pct_src_e s, input pct_place_e p, input logic [3:0] l,
    input logic a);
    return {19'h0, a, l, 1'b0, p, s, n};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk_in);
    awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk_in);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
      if (bv && bre) break;
      if (bv) bre <= 1'b1;
    end
    rsp = brsp;
    bre <= 1'b0;
    if (n == 50) fails++;
  endtask
  task automatic rdx(input logic [7:0] a);
    int n;
    @(posedge core_clk_in);
    arv <= 1'b1; ara <= a;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk_in);
      if (arv && arr) arv <= 1'b0;
      if (rv && rre) break;
      if (rv) rre <= 1'b1;
    end
    rd = rdat;
    rsp = rrsp;
    rre <= 1'b0;
    if (n == 50) fails++;
  endtask
  task automatic cr(input logic [7:0] a, input logic [31:0] e);
    rdx(a);
    `CHK(rsp, 2'b00);
    `CHK(rd, e);
  endtask
  task automatic send(input logic [15:0] x, input logic [15:0] r);
    @(posedge core_clk_in);
    st <= 1'b1; rxw <= x; rfw <= r;
    @(posedge core_clk_in);
    st <= 1'b0;
    repeat (18) @(posedge core_clk_in);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs;
    cr(CFG_OFS, CFG_RST);
    cr(STATUS_OFS, 32'h0);
    rdx(8'h38);
    `CHK(rsp, 2'b11);
    wr(8'h3c, 32'h1);
    `CHK(rsp, 2'b11);
    wr(CFG_OFS, 32'hffff_ffff);
    cr(CFG_OFS, CFG_WMASK);
  endtask
  task automatic t_err;
    int k;
    // match set so that a wrong source would fire at bit 3
    wr(MATCH_LO_OFS, 32'h3);
    wr(CFG_OFS, cfg(3'd0, SRC_ERR, PL_BOTTOM, 4'd0, 1'b1));
    wr(IRQ_EN_OFS, 32'h0);
    wr(CTRL_OFS, 32'h1);
    send(16'h008c, 16'h000c);
    cr(STATUS_OFS, 32'h100);
    wr(RD_START_OFS, 32'h0);
    cr(TRIG_OFS_OFS, 32'd7);
    cr(IRQ_STS_OFS, 32'h3);
    wr(CTRL_OFS, 32'h10);
    rd = 32'h0;
    for (k = 0; k < 20 && !rd[31]; k++) rdx(RD_DATA_OFS);
    `CHK(rd, 32'h8100_808c);
    cr(STATUS_OFS, 32'h102);
    wr(IRQ_EN_OFS, 32'h4);
    wr(CTRL_OFS, 32'h20);
    cr(STATUS_OFS, 32'h100);
    `CHK(irq, 1'b1);
    wr(IRQ_CLR_OFS, 32'h7);
    cr(IRQ_STS_OFS, 32'h0);
    `CHK(irq, 1'b0);
  endtask
  task automatic t_man;
    int k;
    wr(CFG_OFS, cfg(3'd1, SRC_MANUAL, PL_BOTTOM, 4'd0, 1'b0));
    wr(CTRL_OFS, 32'h1);
    send(16'h00ff, 16'h0000);
    cr(STATUS_OFS, 32'h1);
    wr(CTRL_OFS, 32'h2);
    send(16'h0000, 16'h0000);
    cr(STATUS_OFS, 32'h101);
    wr(CTRL_OFS, 32'h2);
    send(16'h0000, 16'h0000);
    cr(STATUS_OFS, 32'h200);
    `CHK(irq, 1'b0);
    // range read from block 1, count clamped to the two captured
    wr(RD_START_OFS, 32'h1);
    wr(RD_COUNT_OFS, 32'h5);
    cr(TRIG_OFS_OFS, 32'd8);
    wr(CTRL_OFS, 32'h10);
    rd = 32'h0;
    for (k = 0; k < 20 && !rd[31]; k++) rdx(RD_DATA_OFS);
    `CHK(rd, 32'h8000_0000);
    wr(CTRL_OFS, 32'h20);
    cr(STATUS_OFS, 32'h200);
    wr(IRQ_CLR_OFS, 32'h7);
  endtask
  task automatic t_ext;
    wr(CFG_OFS, cfg(3'd0, SRC_EXT, PL_BOTTOM, 4'd0, 1'b0));
    wr(CTRL_OFS, 32'h1);
    send(16'h0f0f, 16'h0000);
    cr(STATUS_OFS, 32'h1);
    @(posedge core_clk_in);
    aux_n <= 1'b0;
    send(16'h0000, 16'h0000);
    cr(STATUS_OFS, 32'h100);
    aux_n <= 1'b1;
  endtask
  task automatic t_match;
    wr(CFG_OFS, cfg(3'd0, SRC_MATCH, PL_BOTTOM, 4'd1, 1'b0));
    wr(MATCH_LO_OFS, 32'h7e);
    wr(MASK_LO_OFS, 32'h0);
    wr(CTRL_OFS, 32'h1);
    send(16'h0066, 16'h0066);
    cr(STATUS_OFS, 32'h1);
    wr(MASK_LO_OFS, 32'h18);
    send(16'h0066, 16'h0066);
    cr(STATUS_OFS, 32'h100);
    // bit 7 selects combined mode; off-nibble match must not fire
    wr(CFG_OFS, cfg(3'd0, SRC_MATCH, PL_BOTTOM, 4'd1, 1'b0) | 32'h80);
    wr(CTRL_OFS, 32'h1);
    send(16'h0198, 16'h0198);
    cr(STATUS_OFS, 32'h1);
    send(16'h0066, 16'h0066);
    cr(STATUS_OFS, 32'h100);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge core_clk_in);
    srst_in <= 1'b0;
    t_regs;
    t_err;
    t_man;
    t_ext;
    t_match;
    give_verdict;
  end
  // whole run needs about 450 cycles
  initial begin
    repeat (8000) @(posedge core_clk_in);
    fails++;
    give_verdict;
  end
endmodule
bind pct_capture pct_capture_sva u_pct_capture_sva (
  .core_clk_in(core_clk_in), .srst_in(srst_in),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bresp(s_axi_bresp), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rready(s_axi_rready), .irq_out(irq_out));

// File: tb/pct_capture_sva.sv
/*
 pct_capture_sva: bus and interrupt checks on the capture block.
 Assumes it is bound to pct_capture and sees only its ports.
*/
`timescale 1ns/1ps
module pct_capture_sva
  import pct_pkg::*;
(
  input wire logic        core_clk_in,
  input wire logic        srst_in,
  input wire logic        s_axi_awvalid,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rready,
  input wire logic        irq_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  wire       aw_t = s_axi_awvalid && s_axi_awready;
  wire       w_t  = s_axi_wvalid && s_axi_wready;
  wire       ar_t = s_axi_arvalid && s_axi_arready;
  wire       en_wr = aw_t && w_t && s_axi_wstrb[0]
                     && (s_axi_awaddr == IRQ_EN_OFS);
  logic [2:0] en_q;
  // mirror of the enable register, decoded from the bus
  always_ff @(posedge core_clk_in) begin
    if (srst_in) en_q <= 3'h0;
    else if (en_wr) en_q <= s_axi_wdata[2:0];
  end
  // ==========================================================
  // assertions
  a_write_answer: assert property (aw_t && w_t |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_ready_parked: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (ar_t |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_bad_read: assert property (ar_t && s_axi_araddr > 8'h34
    |=> s_axi_rresp == 2'b11 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_bad_write: assert property (aw_t && w_t && s_axi_awaddr > 8'h34
    |-> ##2 s_axi_bresp == 2'b11)
    else $error("unmapped write not refused");
  a_irq_masked: assert property ((en_q == 3'h0)[*3] |=> !irq_out)
    else $error("interrupt with all sources masked");
  c_write: cover property (aw_t && w_t);
  c_bad_read: cover property (ar_t && s_axi_araddr > 8'h34);
  c_irq: cover property ($rose(irq_out));
endmodule

// File: tb/pct_stream_src.sv
/*
 pct_stream_src: far-side model sending 16 received and reference
 bits, lsb first, one per clock after a start pulse.
*/
`timescale 1ns/1ps
module pct_stream_src
  import pct_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        srst_in,
  input  wire logic        start_in,
  input  wire logic [15:0] rx_word_in,
  input  wire logic [15:0] ref_word_in,
  output pct_pkg::pct_rx_s rx_out
);
  logic [4:0] idx_q;
  logic       tog_q;
  wire        live = (idx_q < 5'd16);
  always_ff @(posedge core_clk_in) begin
    tog_q <= srst_in ? 1'b0 : ~tog_q;
    if (srst_in) idx_q <= 5'd16;
    else if (start_in) idx_q <= 5'd0;
    else if (live) idx_q <= idx_q + 5'd1;
  end
  // idle lines toggle so a stale bit is never mistaken for data
  assign rx_out.valid   = live;
  assign rx_out.rx_bit  = live ? rx_word_in[idx_q[3:0]] : tog_q;
  assign rx_out.ref_bit = live ? ref_word_in[idx_q[3:0]] : ~tog_q;
endmodule
